// >>> rtl/urs_defines.svh
`ifndef URS_DEFINES_SVH
`define URS_DEFINES_SVH

// -----------------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------------
`define URS_OFF_STATUS   12'h000
`define URS_OFF_DATA     12'h004
`define URS_OFF_CTRL     12'h008
`define URS_OFF_BAUD     12'h00c
`define URS_OFF_IRQEN    12'h010

// -----------------------------------------------------------------------
// Status field positions
// -----------------------------------------------------------------------
`define URS_ST_RXAVAIL   0
`define URS_ST_IDLE      1
`define URS_ST_OVERRUN   2
`define URS_ST_NOISE     3
`define URS_ST_FRAME     4
`define URS_ST_PARITY    5
`define URS_ST_TXEMPTY   6
`define URS_ST_TXIDLE    7

// -----------------------------------------------------------------------
// Control field positions
// -----------------------------------------------------------------------
`define URS_CT_RXEN      0
`define URS_CT_NINEBIT   1
`define URS_CT_TWOSTOP   2
`define URS_CT_PAREN     3
`define URS_CT_PARODD    4
`define URS_CT_ADDREN    5
`define URS_CT_RXIE      6
`define URS_CT_WAKE      7
`define URS_CT_TXEIE     8
`define URS_CT_TXIIE     9

// Interrupt enable positions
`define URS_IE_UART      0
`define URS_IE_MF        1
`define URS_IE_GLOBAL    2

// -----------------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------------
`define URS_CTRL_RST     10'h000
`define URS_BAUD_RST     16'h001a
`define URS_OVERSAMPLE   16
`define URS_FIFO_DEPTH   4

`endif

// >>> rtl/urs_pkg.sv
`default_nettype none

// -----------------------------------------------------------------------
// Receiver types
// -----------------------------------------------------------------------
package urs_pkg;
  typedef enum logic [2:0] {
    RxIdle,
    RxStart,
    RxData,
    RxParity,
    RxStop,
    RxWaitHigh
  } urs_rx_state_t;
endpackage

`default_nettype wire

// >>> rtl/urs_receiver.sv
`include "urs_defines.svh"
`default_nettype none
module urs_receiver #(
  parameter int DEPTH = `URS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line and power state
  input  wire logic        rxPin,
  input  wire logic        sleepMode,
  // Transmitter conditions from the sibling block
  input  wire logic        txEmpty,
  input  wire logic        txIdle,
  // Interrupt request, active low; receive and wake pulse it, enabled transmit sources hold it low
  output logic             uartIrqN,
  output logic             wakeUp
);

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  logic access;      // Access phase of any transfer
  logic wrCtrl;      // Control write
  logic wrBaud;      // Baud divisor write
  logic wrIrqEn;     // Interrupt enable write
  logic rdStatus;    // Status read or write access arms clearing
  logic rdData;      // Data register read
  assign access   = psel & penable;
  assign pready   = 1'b1;   // Zero wait states keep the master simple
  assign wrCtrl   = access & pwrite & (paddr == `URS_OFF_CTRL);
  assign wrBaud   = access & pwrite & (paddr == `URS_OFF_BAUD);
  assign wrIrqEn  = access & pwrite & (paddr == `URS_OFF_IRQEN);
  assign rdStatus = access & (paddr == `URS_OFF_STATUS);
  assign rdData   = access & ~pwrite & (paddr == `URS_OFF_DATA);

  // ---------------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------------
  logic [9:0]  ctrl_q, ctrl_d;          // Control bits
  logic [15:0] baud_q, baud_d;          // Oversample tick divisor
  logic [2:0]  irqEn_q, irqEn_d;        // Uart, mf, global enables
  logic [15:0] div_q, div_d;            // Tick divider
  logic [2:0]  syn_q, syn_d;            // Two-flop sync plus history
  logic [1:0]  vote_q, vote_d;          // Earlier samples for voting
  logic [3:0]  phase_q, phase_d;        // Position within a bit
  logic [3:0]  bitCnt_q, bitCnt_d;      // Bits received
  logic [8:0]  shift_q, shift_d;        // Receive shift register
  logic        parBit_q, parBit_d;      // Received parity bit
  logic        stop2_q, stop2_d;        // Second stop bit pending
  logic        noisy_q, noisy_d;        // Noise seen in frame
  logic        badStop_q, badStop_d;    // A stop bit read low
  urs_pkg::urs_rx_state_t st_q, st_d;   // Receiver state
  logic [8:0]  fifo_q [DEPTH];          // Receive FIFO storage
  logic [8:0]  fifoIn;                  // Word pushed this cycle
  logic [1:0]  rdPtr_q, rdPtr_d;
  logic [1:0]  wrPtr_q, wrPtr_d;
  logic [2:0]  count_q, count_d;        // FIFO occupancy
  logic        armed_q, armed_d;        // Status accessed, awaiting read
  logic        idle_q, idle_d;
  logic        over_q, over_d;
  logic        noise_q, noise_d;
  logic        frame_q, frame_d;
  logic        parErr_q, parErr_d;
  logic        push;                    // Word completes this cycle
  logic        pop;                     // Software takes a word
  logic        irqReq;                  // Any enabled source this cycle
  logic        irqPend_q, irqPend_d;    // Drives the low pulse
  logic        wake_q, wake_d;
  logic        tick;                    // Sixteenth-bit enable
  logic        sample;                  // Majority-voted line level
  logic        line;                    // Synchronised line level
  logic [3:0]  lastBit;                 // Final data bit index
  logic [8:0]  word;                    // Word as it lands in FIFO

  assign line = syn_q[1];

  // ---------------------------------------------------------------------
  // Tick divider and sampling
  // ---------------------------------------------------------------------
  // Divider freezes while asleep, which is how reception pauses
  always_comb begin
    div_d = div_q;
    tick  = 1'b0;
    if (!sleepMode && ctrl_q[`URS_CT_RXEN]) begin
      if (div_q >= baud_q) begin
        div_d = 16'h0000;
        tick  = 1'b1;
      end else begin
        div_d = div_q + 16'h0001;
      end
    end
  end

  // Synchroniser: first flop is read only by the second
  always_comb begin
    syn_d  = {syn_q[1], syn_q[0], rxPin};
    vote_d = vote_q;
    if (tick) begin
      vote_d = {vote_q[0], line};
    end
  end

  assign sample = (vote_q[1] & vote_q[0]) | (vote_q[1] & line)
                | (vote_q[0] & line);
  assign lastBit = ctrl_q[`URS_CT_NINEBIT] ? 4'd8 : 4'd7;

  // ---------------------------------------------------------------------
  // Receive state machine
  // ---------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    phase_d   = phase_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    parBit_d  = parBit_q;
    stop2_d   = stop2_q;
    noisy_d   = noisy_q;
    badStop_d = badStop_q;
    push      = 1'b0;
    if (!ctrl_q[`URS_CT_RXEN]) begin
      st_d = urs_pkg::RxIdle;
    end else if (tick) begin
      phase_d = phase_q + 4'h1;
      // Sample at bit centre; vote spread signals noise
      if (phase_q == 4'h8 && st_q != urs_pkg::RxIdle
          && st_q != urs_pkg::RxWaitHigh) begin
        if (!(vote_q[1] == vote_q[0] && vote_q[0] == line)) begin
          noisy_d = 1'b1;
        end
      end
      unique case (st_q)
        urs_pkg::RxIdle: begin
          if (!line) begin
            st_d      = urs_pkg::RxStart;
            phase_d   = 4'h0;
            noisy_d   = 1'b0;
            badStop_d = 1'b0;
          end
        end
        urs_pkg::RxStart: begin
          if (phase_q == 4'h8) begin
            if (sample) begin
              st_d = urs_pkg::RxIdle;   // False start, a glitch
            end
          end else if (phase_q == 4'hf) begin
            st_d     = urs_pkg::RxData;
            bitCnt_d = 4'h0;
          end
        end
        urs_pkg::RxData: begin
          if (phase_q == 4'h8) begin
            shift_d = {sample, shift_q[8:1]};
          end else if (phase_q == 4'hf) begin
            if (bitCnt_q == lastBit) begin
              st_d = ctrl_q[`URS_CT_PAREN] ? urs_pkg::RxParity
                                           : urs_pkg::RxStop;
              stop2_d = ctrl_q[`URS_CT_TWOSTOP];
            end
            bitCnt_d = bitCnt_q + 4'h1;
          end
        end
        urs_pkg::RxParity: begin
          if (phase_q == 4'h8) begin
            parBit_d = sample;
          end else if (phase_q == 4'hf) begin
            st_d = urs_pkg::RxStop;
          end
        end
        urs_pkg::RxStop: begin
          if (phase_q == 4'h8) begin
            if (!sample) begin
              badStop_d = 1'b1;
            end
            if (!stop2_q) begin
              push = 1'b1;
              st_d = (badStop_q | ~sample) ? urs_pkg::RxWaitHigh
                                          : urs_pkg::RxIdle;
            end
          end else if (phase_q == 4'hf && stop2_q) begin
            stop2_d = 1'b0;
          end
        end
        urs_pkg::RxWaitHigh: begin
          // low line is not a start
          if (sample) begin
            st_d = urs_pkg::RxIdle;
          end
        end
        default: st_d = urs_pkg::RxIdle;
      endcase
    end
  end

  // Nine-bit words keep the top bit; eight-bit words sit low
  assign word = ctrl_q[`URS_CT_NINEBIT] ? shift_q : {1'b0, shift_q[8:1]};

  // ---------------------------------------------------------------------
  // FIFO and status flags
  // ---------------------------------------------------------------------
  assign pop = rdData & (count_q != 3'h0);
  assign fifoIn = word;

  always_comb begin
    logic parityOk;
    logic full;
    parityOk  = 1'b1;
    full      = (count_q == 3'(DEPTH));
    rdPtr_d   = rdPtr_q;
    wrPtr_d   = wrPtr_q;
    count_d   = count_q;
    armed_d   = armed_q;
    idle_d    = idle_q;
    over_d    = over_q;
    noise_d   = noise_q;
    frame_d   = frame_q;
    parErr_d  = parErr_q;
    parityOk  = ((^word) ^ parBit_q) == ctrl_q[`URS_CT_PARODD];
    if (rdStatus) begin
      armed_d = 1'b1;
    end
    if (rdData && armed_q) begin
      armed_d  = 1'b0;
      over_d   = 1'b0;
      noise_d  = 1'b0;
    end
    if (pop) begin
      rdPtr_d = rdPtr_q + 2'h1;
      count_d = count_q - 3'h1;
      frame_d = 1'b0;
      parErr_d = 1'b0;
    end
    if (st_q == urs_pkg::RxIdle && st_d != urs_pkg::RxIdle) begin
      idle_d = 1'b0;
    end
    if (push) begin
      idle_d = 1'b1;
      if (full && !pop) begin
        over_d = 1'b1;
      end else begin
        wrPtr_d = wrPtr_q + 2'h1;
        count_d = count_q + (pop ? 3'h0 : 3'h1);
        if (noisy_q) begin
          noise_d = 1'b1;
        end
        // Voted level, so one noisy sample cannot fake a frame error
        if (badStop_q || !sample) begin
          frame_d = 1'b1;
        end
        if (ctrl_q[`URS_CT_PAREN] && !parityOk) begin
          parErr_d = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt combine
  // ---------------------------------------------------------------------
  always_comb begin
    logic rxEv;
    logic addrOk;
    rxEv   = 1'b0;
    addrOk = 1'b0;
    addrOk = !ctrl_q[`URS_CT_ADDREN]
           || (ctrl_q[`URS_CT_NINEBIT] ? word[8] : word[7]);
    rxEv = ctrl_q[`URS_CT_RXIE] && push
         && (addrOk || (count_q == 3'(DEPTH)));
    wake_d = sleepMode && ctrl_q[`URS_CT_WAKE] && ctrl_q[`URS_CT_RXEN]
           && ctrl_q[`URS_CT_RXIE] && syn_q[2] && !line;
    irqReq = rxEv || wake_q
           || (ctrl_q[`URS_CT_TXEIE] && txEmpty)
           || (ctrl_q[`URS_CT_TXIIE] && txIdle);
    irqPend_d = irqReq && (&irqEn_q);
  end

  // ---------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------
  // status flags have no write path
  always_comb begin
    ctrl_d  = ctrl_q;
    baud_d  = baud_q;
    irqEn_d = irqEn_q;
    if (wrCtrl) begin
      ctrl_d = pwdata[9:0];
    end
    if (wrBaud) begin
      baud_d = pwdata[15:0];
    end
    if (wrIrqEn) begin
      irqEn_d = pwdata[2:0];
    end
  end

  // Read mux, unmapped addresses read zero with no error
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      `URS_OFF_STATUS: begin
        prdata[`URS_ST_RXAVAIL] = (count_q != 3'h0); // avail level
        prdata[`URS_ST_IDLE]    = idle_q;
        prdata[`URS_ST_OVERRUN] = over_q;
        prdata[`URS_ST_NOISE]   = noise_q;
        prdata[`URS_ST_FRAME]   = frame_q;
        prdata[`URS_ST_PARITY]  = parErr_q;
        prdata[`URS_ST_TXEMPTY] = txEmpty;
        prdata[`URS_ST_TXIDLE]  = txIdle;
      end
      `URS_OFF_DATA:  prdata[8:0]  = fifo_q[rdPtr_q];
      `URS_OFF_CTRL:  prdata[9:0]  = ctrl_q;
      `URS_OFF_BAUD:  prdata[15:0] = baud_q;
      `URS_OFF_IRQEN: prdata[2:0]  = irqEn_q;
      default:        prdata       = 32'h0000_0000;
    endcase
  end

  assign uartIrqN = ~irqPend_q;
  assign wakeUp   = wake_q;

  // ---------------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------------
  // errors clear on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q    <= `URS_CTRL_RST;
      baud_q    <= `URS_BAUD_RST;
      irqEn_q   <= 3'h0;
      div_q     <= 16'h0000;
      syn_q     <= 3'h7;
      vote_q    <= 2'h3;
      phase_q   <= 4'h0;
      bitCnt_q  <= 4'h0;
      shift_q   <= 9'h000;
      parBit_q  <= 1'b0;
      stop2_q   <= 1'b0;
      noisy_q   <= 1'b0;
      badStop_q <= 1'b0;
      st_q      <= urs_pkg::RxIdle;
      rdPtr_q   <= 2'h0;
      wrPtr_q   <= 2'h0;
      count_q   <= 3'h0;
      armed_q   <= 1'b0;
      idle_q    <= 1'b1;
      over_q    <= 1'b0;
      noise_q   <= 1'b0;
      frame_q   <= 1'b0;
      parErr_q  <= 1'b0;
      irqPend_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      baud_q    <= baud_d;
      irqEn_q   <= irqEn_d;
      div_q     <= div_d;
      syn_q     <= syn_d;
      vote_q    <= vote_d;
      phase_q   <= phase_d;
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      parBit_q  <= parBit_d;
      stop2_q   <= stop2_d;
      noisy_q   <= noisy_d;
      badStop_q <= badStop_d;
      st_q      <= st_d;
      rdPtr_q   <= rdPtr_d;
      wrPtr_q   <= wrPtr_d;
      count_q   <= count_d;
      armed_q   <= armed_d;
      idle_q    <= idle_d;
      over_q    <= over_d;
      noise_q   <= noise_d;
      frame_q   <= frame_d;
      parErr_q  <= parErr_d;
      irqPend_q <= irqPend_d;
      wake_q    <= wake_d;
    end
  end

  // FIFO storage, one word per entry
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_fifo
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          fifo_q[i] <= 9'h000;
        end else if (push && wrPtr_q == 2'(i)
                     && (count_q != 3'(DEPTH) || pop)) begin
          fifo_q[i] <= fifoIn;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_overrun;
    @(posedge ref_clk) disable iff (rst)
      (push && count_q == 3'(DEPTH) && !pop) |=> over_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("no overrun");

  property p_keep;
    @(posedge ref_clk) disable iff (rst)
      (push && count_q == 3'(DEPTH) && !pop) |=> count_q == 3'(DEPTH);
  endproperty
  a_keep: assert property (p_keep) else $error("fifo changed");

  property p_avail;
    @(posedge ref_clk) disable iff (rst)
      (push && count_q == 3'h0) |=> count_q == 3'h1 && idle_q;
  endproperty
  a_avail: assert property (p_avail) else $error("avail not set");

  property p_idle;
    @(posedge ref_clk) disable iff (rst)
      (st_q == urs_pkg::RxStart) |-> !idle_q;
  endproperty
  a_idle: assert property (p_idle) else $error("idle in frame");

  property p_wait;
    @(posedge ref_clk) disable iff (rst)
      (st_q == urs_pkg::RxWaitHigh && !sample) |=> !push;
  endproperty
  a_wait: assert property (p_wait) else $error("data after break");

  property p_irqmask;
    @(posedge ref_clk) disable iff (rst)
      !(&irqEn_q) |=> uartIrqN;
  endproperty
  a_irqmask: assert property (p_irqmask) else $error("irq masked");

  property p_overclr;
    @(posedge ref_clk) disable iff (rst)
      (over_q && !(rdData && armed_q)) |=> over_q;
  endproperty
  a_overclr: assert property (p_overclr) else $error("overrun lost");

  property p_noiseclr;
    @(posedge ref_clk) disable iff (rst)
      (noise_q && !(rdData && armed_q)) |=> noise_q;
  endproperty
  a_noiseclr: assert property (p_noiseclr) else $error("noise lost");

  // Frame that ends on a low stop bit, a break among them
  sequence s_badEnd;
    push && (badStop_q || !sample);
  endsequence

  property p_brkwait;
    @(posedge ref_clk) disable iff (rst)
      s_badEnd |=> (st_q == urs_pkg::RxWaitHigh) && idle_q;
  endproperty
  a_brkwait: assert property (p_brkwait) else $error("no break wait");

endmodule
`default_nettype wire

// >>> dv/urs_serial_src.sv
`default_nettype none
// -------------------------------------------------------------------
// Remote serial transmitter on the receive line
// -------------------------------------------------------------------
module urs_serial_src #(
  parameter int BIT = 32
) (
  // Clock
  input  wire logic        ref_clk,
  // Frame request: bits after the start bit, LSB first
  input  wire logic        go,
  input  wire logic [23:0] bits,
  input  wire logic [4:0]  nBits,
  input  wire logic        nz,
  // Serial line and progress
  output logic             line,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;

  // Line rests at the mark level between frames
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end

  // Start bit, then each bit for one bit time; the caller supplies
  // stop bits, so a broken stop or a break is just another pattern
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      line <= 1'b0;
      repeat (BIT) @(posedge ref_clk);
      for (int i = 0; i < int'(nBits); i++) begin
        line <= bits[i];
        if (i == 0 && nz) begin
          // Two-clock glitch mid bit: spoils one vote, not the majority
          repeat (BIT / 2) @(posedge ref_clk);
          line <= ~bits[0];
          repeat (2) @(posedge ref_clk);
          line <= bits[0];
          repeat (BIT / 2 - 2) @(posedge ref_clk);
        end else begin
          repeat (BIT) @(posedge ref_clk);
        end
      end
      line <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/uart_receive_status_irq_tb_top.sv
`default_nettype none
module uart_receive_status_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------
  // Signals and model state
  // -----------------------------------------------------------------
  localparam int BIT = 32;    // Baud register 1: 2 clocks a tick
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        uartIrqN;
  logic        wakeUp;
  logic        rxPin;
  logic        sleepMode = 1'b0;
  logic        txEmpty = 1'b0;
  logic        txIdle = 1'b0;
  logic        go = 1'b0;
  logic        busy;
  logic [23:0] bits = 24'h0;
  logic [4:0]  nBits = 5'h0;
  logic [31:0] r;
  logic [31:0] ctl = 32'h0;
  logic        ovrE = 1'b0;
  logic        nz = 1'b0;   // Ask the source for a noisy first bit
  logic        nzE = 1'b0;  // Expected noise flag
  int          n_fail = 0;
  int          check_count = 0;
  int          irqCnt = 0;
  int          wakeCnt = 0;
  int          x;
  int          q[$];        // Expected FIFO; bit 9 frame, bit 10 parity

  always #10 ref_clk = ~ref_clk;

  urs_receiver u_urs_receiver (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxPin, .sleepMode,
    .txEmpty, .txIdle, .uartIrqN, .wakeUp);
  urs_serial_src #(.BIT(BIT)) u_urs_serial_src (.ref_clk, .go, .bits,
    .nBits, .nz, .line(rxPin), .busy);

  // Count low cycles of the request and high cycles of the wake pulse, off the edge
  always @(negedge ref_clk) begin
    if (uartIrqN === 1'b0) irqCnt++;
    if (wakeUp === 1'b1) wakeCnt++;
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_evt(input int cnt, input bit want);
    chk({31'h0, cnt != 0}, {31'h0, want});
  endtask

  // APB transfer; data taken at the edge that sees pready high
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdr(input logic [11:0] a);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic setc(input logic [31:0] c);
    ctl = c;
    bus(1'b1, 12'h008, c, r);
  endtask

  function automatic logic [31:0] exp_st();
    logic [31:0] h;
    h = (q.size() != 0) ? 32'(q[0]) : 32'h0;
    return {24'h0, txIdle, txEmpty, h[10], h[9], nzE, ovrE, 1'b1,
            q.size() != 0};
  endfunction

  // Status then data read; the pair releases overrun
  task automatic pop();
    rdr(12'h000);
    chk(r, exp_st());
    rdr(12'h004);
    chk(r, 32'(q.pop_front() & 'h1ff));
    ovrE = 1'b0;
    nzE = 1'b0;
  endtask

  // One frame built from the control word, then the model updated
  task automatic send(input int v, input bit bad, input bit pe,
                      input bit brk);
    logic [23:0] b;
    logic        p;
    int          n;
    n = ctl[1] ? 9 : 8;
    p = ^(ctl[1] ? v[8:0] : {1'b0, v[7:0]}) ^ ctl[4] ^ pe;
    b = 24'hffffff;
    for (int k = 0; k < n; k++) b[k] = v[k];
    if (ctl[3]) begin
      b[n] = p;
      n++;
    end
    if (bad) b[n + int'(ctl[2])] = 1'b0;
    n = n + 1 + int'(ctl[2]);
    if (brk) begin
      b = 24'h0;
      n = 20;
    end
    bits <= b;
    nBits <= 5'(n);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (3 * BIT) @(posedge ref_clk);
    rdr(12'h000);
    chk(r & 32'h2, 32'h0);
    while (busy) @(posedge ref_clk);
    repeat (BIT) @(posedge ref_clk);
    if (q.size() < 4) begin
      q.push_back(v | (int'(bad | brk) << 9) | (int'(pe & ctl[3]) << 10));
      nzE = nzE | nz;
    end else begin
      ovrE = 1'b1;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, well above the length of the sequence
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end

  // -----------------------------------------------------------------
  // Sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h46c8));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdr(12'h000);
    chk(r, 32'h2);
    rdr(12'h00c);
    chk(r, 32'h1a);
    rdr(12'h3f0);
    chk(r, 32'h0);
    bus(1'b1, 12'h00c, 32'h1, r);
    bus(1'b1, 12'h010, 32'h7, r);
    setc(32'h41);
    irqCnt = 0;
    send($urandom & 'hff, 0, 0, 0);
    send($urandom & 'hff, 0, 0, 0);
    chk_evt(irqCnt, 1);
    pop();
    pop();
    repeat (5) send($urandom & 'hff, 0, 0, 0);
    repeat (4) pop();
    rdr(12'h000);
    chk(r, exp_st());
    send($urandom & 'hff, 1, 0, 0);
    pop();
    setc(32'h45);
    send($urandom & 'hff, 1, 0, 0);
    pop();
    for (int i = 0; i < 4; i++) begin
      setc(32'h49 | (i[0] << 4));
      send($urandom & 'hff, 0, i[1], 0);
      pop();
    end
    setc(32'h41);
    send(0, 0, 0, 1);
    send($urandom & 'hff, 0, 0, 0);
    pop();
    pop();
    nz <= 1'b1;
    send($urandom & 'hff, 0, 0, 0);
    nz <= 1'b0;
    pop();
    rdr(12'h000);
    chk(r, exp_st());
    // Parity stays off while address detect is on
    for (int i = 0; i < 4; i++) begin
      setc(32'h61 | (i[0] << 1));
      x = ($urandom & 'h7f) | (int'(i[1]) << (7 + int'(i[0])));
      irqCnt = 0;
      send(x, 0, 0, 0);
      chk_evt(irqCnt, i[1]);
      pop();
    end
    setc(32'h41);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 12'h010, 32'h7 ^ (32'h1 << i), r);
      irqCnt = 0;
      send($urandom & 'hff, 0, 0, 0);
      chk_evt(irqCnt, 0);
      pop();
    end
    bus(1'b1, 12'h010, 32'h7, r);
    setc(32'h300);
    for (int i = 0; i < 4; i++) begin
      txEmpty <= i[0];
      txIdle <= i[1];
      repeat (2) @(posedge ref_clk);
      irqCnt = 0;
      repeat (4) @(posedge ref_clk);
      chk_evt(irqCnt, i != 0);
    end
    setc(32'h100);
    txEmpty <= 1'b0;
    repeat (2) @(posedge ref_clk);
    irqCnt = 0;
    repeat (4) @(posedge ref_clk);
    chk_evt(irqCnt, 0);
    bus(1'b1, 12'h000, 32'hff, r);
    rdr(12'h000);
    chk(r, exp_st());
    txIdle <= 1'b0;
    setc(32'hc1);
    sleepMode <= 1'b1;
    bits <= 24'hffffff;
    nBits <= 5'd9;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    wakeCnt = 0;
    irqCnt = 0;
    // Let the source raise busy before waiting on it
    @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
    chk_evt(wakeCnt, 1);
    chk_evt(irqCnt, 1);
    sleepMode <= 1'b0;
    // Leave a frame error standing so the reset has a flag to clear
    send($urandom & 'hff, 1, 0, 0);
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    q.delete();
    @(posedge ref_clk);
    rdr(12'h000);
    chk(r, 32'h2);
    close_out();
  end
endmodule
`default_nettype wire
